// file: codec_control_register_bank.sv
// control register bank of one codec unit with clock dividers and reset sequencing
//
// How it works
// - mode bit 0: program clear, data set
// - mode bit 1 enables mixed program/data
// - mode bits 2,3: digital and serial loopback
// - mode bits 4-6 cascade count picks frames
// - writing one to mode bit 7 resets
// - reset zeroes registers, lasts four divided_master_clock cycles
// - clock bits 0-1 select sample rate
// - sample rate divided_master_clock/2048,1024,512,256; default 2048
// - clock bits 2-3 select serial clock divider
// - serial clock divided_master_clock/8,4,2,1; default 8
// - clock bits 4-6 divide master clock
// - clock bit 7 enables control word echo
// - power bit 0 powers whole unit
// - power bits 1-5 power individual sections
// - power bit 6 enables reference output pin
// - gain bits 0-2 input, 4-6 output
// - gain bit 7 mutes, bit 3 modulator reset
// - dac timing bits 0-4 advance value
// - dac timing bit 5 bypasses interpolator
// - bit 6 enables digital tap, low coefficient
// - tap bits 0-4 analog tap coefficient
// - tap bit 5 single-ended or tap enable
// - tap bit 6 inverts input signal
// - tap bit 7 loopback or tap mute
`timescale 1ns/1ps
`default_nettype none

module codec_control_register_bank
    import codec_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire reg_req_s req,
    output logic wr_ready,
    output reg_resp_s rd_resp,
    input wire logic frame_sync_in,
    output logic own_frame,
    output logic divided_master_clock_tick,
    output logic sclk_tick,
    output logic sample_tick,
    output logic busy,
    output codec_cfg_s cfg
);

    logic [7:0] regs_r [NUM_REGS];
    logic [7:0] regs_nxt [NUM_REGS];
    reset_state_e state_r, state_nxt;
    logic [2:0] rcnt_r, rcnt_nxt;
    reg_resp_s resp_r, resp_nxt;
    logic [2:0] mdiv_r, mdiv_nxt;
    logic [2:0] sdiv_r, sdiv_nxt;
    logic [10:0] srcnt_r, srcnt_nxt;
    logic [2:0] fcnt_r, fcnt_nxt;
    logic own_r, own_nxt;
    logic wr_take, sw_reset;
    logic [2:0] mcd_code, mcd_last;
    logic [3:0] sclk_div;
    logic [11:0] sr_div;

    // configuration is only open in program or mixed mode; pure data mode needs rst
    assign wr_ready = (state_r == ST_RUN) &&
        (!regs_r[ADDR_MODE_CONTROL][MODE_DATA_BIT] ||
         regs_r[ADDR_MODE_CONTROL][MODE_MIXED_BIT]);
    assign wr_take = req.wr && wr_ready && (req.addr < 3'(NUM_REGS));
    assign sw_reset = wr_take && (req.addr == ADDR_MODE_CONTROL) &&
        req.data[MODE_SWRESET_BIT];
    assign busy = (state_r == ST_RESET);

    // register file and reset sequence
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        state_nxt = state_r;
        rcnt_nxt = rcnt_r;
        case (state_r)
            ST_RUN: begin
                if (sw_reset) begin
                    for (int i = 0; i < NUM_REGS; i++) begin
                        regs_nxt[i] = REG_RESET_VALUE;
                    end
                    state_nxt = ST_RESET;
                    rcnt_nxt = RESET_DIVIDED_MASTER_CLOCK_CYCLES;
                end else if (wr_take) begin
                    // reserved bits are stored as written; host keeps them zero
                    regs_nxt[req.addr] = req.data;
                end
            end
            ST_RESET: begin
                // dividers run from reset values, so ticks are divided_master_clock = clk here
                if (divided_master_clock_tick) begin
                    rcnt_nxt = rcnt_r - 3'h1;
                    if (rcnt_r == 3'h1) begin
                        state_nxt = ST_RUN;
                    end
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= REG_RESET_VALUE;
            end
            state_r <= ST_RESET;
            rcnt_r <= RESET_DIVIDED_MASTER_CLOCK_CYCLES;
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= regs_nxt[i];
            end
            state_r <= state_nxt;
            rcnt_r <= rcnt_nxt;
        end
    end

    // read back; the unimplemented eighth address reads as zero
    always_comb begin
        resp_nxt.valid = req.rd;
        resp_nxt.data = 8'h00;
        if (req.rd && (req.addr < 3'(NUM_REGS))) begin
            resp_nxt.data = regs_r[req.addr];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resp_r <= '0;
        end else begin
            resp_r <= resp_nxt;
        end
    end
    assign rd_resp = resp_r;

    // clock dividers, all as enable pulses on clk
    assign mcd_code = regs_r[ADDR_CLOCK_RATE_CONFIG][CLK_MCD_LSB +: 3];
    assign mcd_last = (mcd_code > MCD_MAX_CODE) ? 3'h0 : mcd_code;
    assign divided_master_clock_tick = (mdiv_r >= mcd_last);

    always_comb begin
        case (regs_r[ADDR_CLOCK_RATE_CONFIG][CLK_SCD_LSB +: 2])
            2'h0: sclk_div = SCLK_DIV_0;
            2'h1: sclk_div = SCLK_DIV_1;
            2'h2: sclk_div = SCLK_DIV_2;
            2'h3: sclk_div = SCLK_DIV_3;
            default: sclk_div = SCLK_DIV_0;
        endcase
        case (regs_r[ADDR_CLOCK_RATE_CONFIG][CLK_SR_LSB +: 2])
            2'h0: sr_div = SR_DIV_0;
            2'h1: sr_div = SR_DIV_1;
            2'h2: sr_div = SR_DIV_2;
            2'h3: sr_div = SR_DIV_3;
            default: sr_div = SR_DIV_0;
        endcase
    end

    // a lowered divisor wraps at once rather than running out the old count
    assign sclk_tick = divided_master_clock_tick && ({1'b0, sdiv_r} >= (sclk_div - 4'h1));
    assign sample_tick = divided_master_clock_tick && ({1'b0, srcnt_r} >= (sr_div - 12'h001));

    always_comb begin
        mdiv_nxt = divided_master_clock_tick ? 3'h0 : mdiv_r + 3'h1;
        sdiv_nxt = sdiv_r;
        srcnt_nxt = srcnt_r;
        if (divided_master_clock_tick) begin
            sdiv_nxt = sclk_tick ? 3'h0 : sdiv_r + 3'h1;
            srcnt_nxt = sample_tick ? 11'h000 : srcnt_r + 11'h001;
        end
        if (sw_reset) begin
            mdiv_nxt = 3'h0;
            sdiv_nxt = 3'h0;
            srcnt_nxt = 11'h000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mdiv_r <= 3'h0;
            sdiv_r <= 3'h0;
            srcnt_r <= 11'h000;
        end else begin
            mdiv_r <= mdiv_nxt;
            sdiv_r <= sdiv_nxt;
            srcnt_r <= srcnt_nxt;
        end
    end

    // frame counting in data mode; count restarts on each sample event
    always_comb begin
        fcnt_nxt = fcnt_r;
        own_nxt = 1'b0;
        if (sample_tick || !cfg.operating_mode_select) begin
            fcnt_nxt = 3'h0;
        end else if (frame_sync_in) begin
            fcnt_nxt = fcnt_r + 3'h1;
            // a zero count never matches, even when the frame counter wraps
            own_nxt = ((fcnt_r + 3'h1) == cfg.cascade_count_field) &&
                (cfg.cascade_count_field != 3'h0);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fcnt_r <= 3'h0;
            own_r <= 1'b0;
        end else begin
            fcnt_r <= fcnt_nxt;
            own_r <= own_nxt;
        end
    end
    assign own_frame = own_r;

    // configuration fields, straight from the register flops
    always_comb begin
        cfg.operating_mode_select = regs_r[ADDR_MODE_CONTROL][MODE_DATA_BIT];
        cfg.mixed_mode_enable = regs_r[ADDR_MODE_CONTROL][MODE_MIXED_BIT];
        cfg.digital_loopback_enable = regs_r[ADDR_MODE_CONTROL][MODE_DLB_BIT];
        cfg.serial_port_loopback_enable = regs_r[ADDR_MODE_CONTROL][MODE_SLB_BIT];
        cfg.cascade_count_field = regs_r[ADDR_MODE_CONTROL][MODE_COUNT_LSB +: 3];
        cfg.sample_rate_select = regs_r[ADDR_CLOCK_RATE_CONFIG][CLK_SR_LSB +: 2];
        cfg.serial_clock_divider_select = regs_r[ADDR_CLOCK_RATE_CONFIG][CLK_SCD_LSB +: 2];
        cfg.master_clock_divider_select = mcd_code;
        cfg.control_echo_enable = regs_r[ADDR_CLOCK_RATE_CONFIG][CLK_ECHO_BIT];
        cfg.global_power_up = regs_r[ADDR_POWER_CONTROL][PWR_GLOBAL_BIT];
        // global power-up overrides on; a section bit alone still powers it
        cfg.analog_tap_power = cfg.global_power_up |
            regs_r[ADDR_POWER_CONTROL][PWR_SECTION_LSB];
        cfg.input_amp_power = cfg.global_power_up |
            regs_r[ADDR_POWER_CONTROL][PWR_SECTION_LSB + 1];
        cfg.adc_power = cfg.global_power_up |
            regs_r[ADDR_POWER_CONTROL][PWR_SECTION_LSB + 2];
        cfg.dac_power = cfg.global_power_up |
            regs_r[ADDR_POWER_CONTROL][PWR_SECTION_LSB + 3];
        cfg.reference_power = cfg.global_power_up |
            regs_r[ADDR_POWER_CONTROL][PWR_SECTION_LSB + 4];
        cfg.reference_output_pin = regs_r[ADDR_POWER_CONTROL][PWR_REFERENCE_OUTPUT_PIN_BIT];
        cfg.input_gain_select = regs_r[ADDR_GAIN_MUTE_CONTROL][GAIN_IN_LSB +: 3];
        cfg.modulator_reset = regs_r[ADDR_GAIN_MUTE_CONTROL][GAIN_MODRST_BIT];
        cfg.output_gain_select = regs_r[ADDR_GAIN_MUTE_CONTROL][GAIN_OUT_LSB +: 3];
        cfg.output_mute = regs_r[ADDR_GAIN_MUTE_CONTROL][GAIN_MUTE_BIT];
        cfg.dac_advance_field = regs_r[ADDR_DAC_TIMING_CONTROL][DAC_ADV_LSB +: 5];
        cfg.interpolator_bypass = regs_r[ADDR_DAC_TIMING_CONTROL][DAC_INTERPOLATOR_BYPASS_BIT];
        cfg.digital_tap_enable = regs_r[ADDR_DAC_TIMING_CONTROL][DAC_DIGITAL_TAP_ENABLE_BIT];
        cfg.digital_tap_coefficient = regs_r[ADDR_DIGITAL_GAIN_TAP_LOW];
        cfg.analog_tap_coefficient =
            regs_r[ADDR_ANALOG_GAIN_TAP_CONTROL][AGT_COEF_LSB +: 5];
        cfg.single_ended_or_tap_enable =
            regs_r[ADDR_ANALOG_GAIN_TAP_CONTROL][AGT_SEEN_BIT];
        cfg.input_invert = regs_r[ADDR_ANALOG_GAIN_TAP_CONTROL][AGT_INV_BIT];
        cfg.loopback_or_tap_mute = regs_r[ADDR_ANALOG_GAIN_TAP_CONTROL][AGT_ALB_BIT];
    end

    // helper: divided_master_clock ticks seen while the reset sequence runs
    logic [3:0] busy_ticks_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_ticks_r <= 4'h0;
        end else if (!busy) begin
            busy_ticks_r <= 4'h0;
        end else if (divided_master_clock_tick) begin
            busy_ticks_r <= busy_ticks_r + 4'h1;
        end
    end

    // helper: divided_master_clock ticks since the last serial and sample tick; a gap is only judged
    // once the clock register has stood still for a whole period
    logic [3:0] sgap_r;
    logic [11:0] srgap_r;
    logic sgap_ok_r, srgap_ok_r, clk_cfg_hit;
    assign clk_cfg_hit = sw_reset || (wr_take && (req.addr == ADDR_CLOCK_RATE_CONFIG));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sgap_r <= 4'h0;
            srgap_r <= 12'h000;
            sgap_ok_r <= 1'b0;
            srgap_ok_r <= 1'b0;
        end else begin
            if (sclk_tick) begin
                sgap_r <= 4'h0;
            end else if (divided_master_clock_tick) begin
                sgap_r <= sgap_r + 4'h1;
            end
            if (sample_tick) begin
                srgap_r <= 12'h000;
            end else if (divided_master_clock_tick) begin
                srgap_r <= srgap_r + 12'h001;
            end
            sgap_ok_r <= (sgap_ok_r || sclk_tick) && !clk_cfg_hit;
            srgap_ok_r <= (srgap_ok_r || sample_tick) && !clk_cfg_hit;
        end
    end

    sw_reset_a: assert property (@(posedge clk) disable iff (rst)
        sw_reset |=> busy && (regs_r[ADDR_MODE_CONTROL] == 8'h00) && !wr_ready)
        else $error("software reset did not start");

    busy_lock_a: assert property (@(posedge clk) disable iff (rst)
        busy |-> !wr_ready)
        else $error("write open while reset sequence runs");

    reset_len_a: assert property (@(posedge clk) disable iff (rst)
        $fell(busy) |-> (busy_ticks_r == {1'b0, RESET_DIVIDED_MASTER_CLOCK_CYCLES}))
        else $error("reset sequence not four divided_master_clock cycles");

    write_back_a: assert property (@(posedge clk) disable iff (rst)
        (wr_take && !sw_reset) ##1 !req.wr ##1 (req.rd && req.addr == $past(req.addr, 2)) |=>
        (rd_resp.valid && rd_resp.data == $past(req.data, 3)))
        else $error("register read back differs from write");

    data_lock_a: assert property (@(posedge clk) disable iff (rst)
        (cfg.operating_mode_select && !cfg.mixed_mode_enable) |-> !wr_ready)
        else $error("write open in pure data mode");

    mode_take_a: assert property (@(posedge clk) disable iff (rst)
        (wr_take && req.addr == ADDR_MODE_CONTROL && !sw_reset) |=>
        cfg.mixed_mode_enable == $past(req.data[MODE_MIXED_BIT]) &&
        cfg.operating_mode_select == $past(req.data[MODE_DATA_BIT]))
        else $error("mode bits not taken");

    divided_master_clock_div_a: assert property (@(posedge clk) disable iff (rst)
        (mcd_code == 3'h2 && divided_master_clock_tick) ##1 (mcd_code == 3'h2)[*3] |->
        (!$past(divided_master_clock_tick, 2) && !$past(divided_master_clock_tick) && divided_master_clock_tick))
        else $error("master clock divide by three wrong");

    sclk_default_a: assert property (@(posedge clk) disable iff (rst)
        (sclk_tick && sgap_ok_r && cfg.serial_clock_divider_select == 2'h0) |->
        (sgap_r == SCLK_DIV_0 - 4'h1))
        else $error("serial clock not divided_master_clock over eight");

    sclk_div4_a: assert property (@(posedge clk) disable iff (rst)
        (sclk_tick && sgap_ok_r && cfg.serial_clock_divider_select == 2'h1) |->
        (sgap_r == SCLK_DIV_1 - 4'h1))
        else $error("serial clock not divided_master_clock over four");

    sclk_div2_a: assert property (@(posedge clk) disable iff (rst)
        (sclk_tick && sgap_ok_r && cfg.serial_clock_divider_select == 2'h2) |->
        (sgap_r == SCLK_DIV_2 - 4'h1))
        else $error("serial clock not divided_master_clock over two");

    sclk_full_a: assert property (@(posedge clk) disable iff (rst)
        (sclk_tick && sgap_ok_r && cfg.serial_clock_divider_select == 2'h3) |->
        (sgap_r == SCLK_DIV_3 - 4'h1))
        else $error("serial clock not divided_master_clock");

    sample_2048_a: assert property (@(posedge clk) disable iff (rst)
        (sample_tick && srgap_ok_r && cfg.sample_rate_select == 2'h0) |->
        (srgap_r == SR_DIV_0 - 12'h001))
        else $error("sample rate not divided_master_clock over 2048");

    sample_1024_a: assert property (@(posedge clk) disable iff (rst)
        (sample_tick && srgap_ok_r && cfg.sample_rate_select == 2'h1) |->
        (srgap_r == SR_DIV_1 - 12'h001))
        else $error("sample rate not divided_master_clock over 1024");

    sample_512_a: assert property (@(posedge clk) disable iff (rst)
        (sample_tick && srgap_ok_r && cfg.sample_rate_select == 2'h2) |->
        (srgap_r == SR_DIV_2 - 12'h001))
        else $error("sample rate not divided_master_clock over 512");

    sample_256_a: assert property (@(posedge clk) disable iff (rst)
        (sample_tick && srgap_ok_r && cfg.sample_rate_select == 2'h3) |->
        (srgap_r == SR_DIV_3 - 12'h001))
        else $error("sample rate not divided_master_clock over 256");

    power_or_a: assert property (@(posedge clk) disable iff (rst)
        $rose(cfg.global_power_up) |-> cfg.reference_power && cfg.dac_power &&
        cfg.adc_power && cfg.input_amp_power && cfg.analog_tap_power)
        else $error("global power-up not applied");

    own_frame_a: assert property (@(posedge clk) disable iff (rst)
        own_frame |-> $past(frame_sync_in) && cfg.operating_mode_select &&
        (fcnt_r == cfg.cascade_count_field))
        else $error("own frame flagged at wrong count");

endmodule

`default_nettype wire

// file: codec_ctrl_pkg.sv
// shared constants, types and register map of the codec control register bank
package codec_ctrl_pkg;

    // register indices, 3-bit register address of a control word
    localparam logic [2:0] ADDR_MODE_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_CLOCK_RATE_CONFIG = 3'h1;
    localparam logic [2:0] ADDR_POWER_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_GAIN_MUTE_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_DAC_TIMING_CONTROL = 3'h4;
    localparam logic [2:0] ADDR_ANALOG_GAIN_TAP_CONTROL = 3'h5;
    localparam logic [2:0] ADDR_DIGITAL_GAIN_TAP_LOW = 3'h6;
    localparam int NUM_REGS = 7;

    localparam logic [7:0] REG_RESET_VALUE = 8'h00;

    // mode_control fields
    localparam int MODE_DATA_BIT = 0;
    localparam int MODE_MIXED_BIT = 1;
    localparam int MODE_DLB_BIT = 2;
    localparam int MODE_SLB_BIT = 3;
    localparam int MODE_COUNT_LSB = 4;
    localparam int MODE_SWRESET_BIT = 7;
    // clock_rate_config fields
    localparam int CLK_SR_LSB = 0;
    localparam int CLK_SCD_LSB = 2;
    localparam int CLK_MCD_LSB = 4;
    localparam int CLK_ECHO_BIT = 7;
    // power_control fields
    localparam int PWR_GLOBAL_BIT = 0;
    localparam int PWR_SECTION_LSB = 1;
    localparam int PWR_REFERENCE_OUTPUT_PIN_BIT = 6;
    localparam int PWR_RESERVED_BIT = 7;
    // gain_mute_control fields
    localparam int GAIN_IN_LSB = 0;
    localparam int GAIN_MODRST_BIT = 3;
    localparam int GAIN_OUT_LSB = 4;
    localparam int GAIN_MUTE_BIT = 7;
    // dac_timing_control fields
    localparam int DAC_ADV_LSB = 0;
    localparam int DAC_INTERPOLATOR_BYPASS_BIT = 5;
    localparam int DAC_DIGITAL_TAP_ENABLE_BIT = 6;
    localparam int DAC_RESERVED_BIT = 7;
    // analog_gain_tap_control fields
    localparam int AGT_COEF_LSB = 0;
    localparam int AGT_SEEN_BIT = 5;
    localparam int AGT_INV_BIT = 6;
    localparam int AGT_ALB_BIT = 7;

    // reset sequence length in divided master clock cycles
    localparam logic [2:0] RESET_DIVIDED_MASTER_CLOCK_CYCLES = 3'h4;

    // divided master clock: divide code+1 for codes 0..4, else by one
    localparam logic [2:0] MCD_MAX_CODE = 3'h4;

    // serial clock divisors for codes 00..11
    localparam logic [3:0] SCLK_DIV_0 = 4'h8;
    localparam logic [3:0] SCLK_DIV_1 = 4'h4;
    localparam logic [3:0] SCLK_DIV_2 = 4'h2;
    localparam logic [3:0] SCLK_DIV_3 = 4'h1;

    // sample rate divisors for codes 00..11
    localparam logic [11:0] SR_DIV_0 = 12'h800;
    localparam logic [11:0] SR_DIV_1 = 12'h400;
    localparam logic [11:0] SR_DIV_2 = 12'h200;
    localparam logic [11:0] SR_DIV_3 = 12'h100;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] data;
    } reg_req_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } reg_resp_s;

    typedef struct packed {
        logic operating_mode_select;
        logic mixed_mode_enable;
        logic digital_loopback_enable;
        logic serial_port_loopback_enable;
        logic [2:0] cascade_count_field;
        logic [1:0] sample_rate_select;
        logic [1:0] serial_clock_divider_select;
        logic [2:0] master_clock_divider_select;
        logic control_echo_enable;
        logic global_power_up;
        logic analog_tap_power;
        logic input_amp_power;
        logic adc_power;
        logic dac_power;
        logic reference_power;
        logic reference_output_pin;
        logic [2:0] input_gain_select;
        logic modulator_reset;
        logic [2:0] output_gain_select;
        logic output_mute;
        logic [4:0] dac_advance_field;
        logic interpolator_bypass;
        logic digital_tap_enable;
        logic [7:0] digital_tap_coefficient;
        logic [4:0] analog_tap_coefficient;
        logic single_ended_or_tap_enable;
        logic input_invert;
        logic loopback_or_tap_mute;
    } codec_cfg_s;

    typedef enum logic {ST_RUN, ST_RESET} reset_state_e;

endpackage

// file: host_dsp_model.sv
// host serial-port model issuing register writes, reads and frame syncs
`timescale 1ns/1ps
`default_nettype none
module host_dsp_model
    import codec_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic wr_ready,
    output reg_req_s req,
    output logic frame_sync_in
);
    initial begin
        req = '0;
        frame_sync_in = 1'b0;
    end
    // holds the write until wr_ready is seen; a refused write gives up after lim cycles
    task automatic write(input logic [2:0] a, input logic [7:0] d, input int lim,
                         output logic [7:0] sent, output bit ok);
        int n;
        sent = d;
        ok = 1'b0;
        n = 0;
        if (a == ADDR_POWER_CONTROL || a == ADDR_DAC_TIMING_CONTROL) begin
            sent[7] = 1'b0;
        end
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, data: sent};
        while (!ok && n < lim) begin
            @(negedge clk);
            ok = (wr_ready === 1'b1);
            n++;
        end
        @(posedge clk);
        req <= '0;
    endtask
    task automatic read(input logic [2:0] a);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic frame();
        @(posedge clk);
        frame_sync_in <= 1'b1;
        @(posedge clk);
        frame_sync_in <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: codec_control_register_bank_bench.sv
// self-checking bench of the codec control register bank
`timescale 1ns/1ps
`default_nettype none
module codec_control_register_bank_bench
    import codec_ctrl_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    reg_req_s req;
    reg_resp_s rd_resp;
    logic frame_sync_in, wr_ready, own_frame, divided_master_clock_tick, sclk_tick, sample_tick, busy;
    codec_cfg_s cfg;
    int n_fail = 0;
    int n_checks = 0;
    logic [7:0] sh [8];
    logic [7:0] q [$];
    logic [31:0] seed = 32'hBA99;
    int g;

    always #5 clk = ~clk;

    codec_control_register_bank u_codec_control_register_bank (.clk(clk), .rst(rst),
        .req(req), .wr_ready(wr_ready), .rd_resp(rd_resp), .frame_sync_in(frame_sync_in),
        .own_frame(own_frame), .divided_master_clock_tick(divided_master_clock_tick), .sclk_tick(sclk_tick),
        .sample_tick(sample_tick), .busy(busy), .cfg(cfg));
    host_dsp_model u_host_dsp_model (.clk(clk), .wr_ready(wr_ready), .req(req),
        .frame_sync_in(frame_sync_in));

    task automatic test_done();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        n_fail++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) fail($sformatf("read data %h expected %h", got, exp));
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        n_checks++;
        if (got !== exp) fail($sformatf("%s got %b", m, got));
    endtask
    task automatic chk_cnt(input int got, input int exp, input string m);
        n_checks++;
        if (got != exp) fail($sformatf("%s got %0d expected %0d", m, got, exp));
    endtask
    // sections follow the global power bit or their own bit
    function automatic codec_cfg_s exp_cfg();
        logic gp;
        gp = sh[2][0];
        return {sh[0][0], sh[0][1], sh[0][2], sh[0][3], sh[0][6:4], sh[1][1:0], sh[1][3:2],
            sh[1][6:4], sh[1][7], gp, sh[2][1] | gp, sh[2][2] | gp, sh[2][3] | gp,
            sh[2][4] | gp, sh[2][5] | gp, sh[2][6], sh[3][2:0], sh[3][3], sh[3][6:4], sh[3][7],
            sh[4][4:0], sh[4][5], sh[4][6], sh[6], sh[5][4:0], sh[5][5], sh[5][6], sh[5][7]};
    endfunction
    task automatic chk_cfg();
        n_checks++;
        if (cfg !== exp_cfg()) fail($sformatf("cfg %h expected %h", cfg, exp_cfg()));
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic tick(input int sel);
        return sel == 0 ? divided_master_clock_tick : (sel == 1 ? sclk_tick : sample_tick);
    endfunction

    task automatic do_write(input logic [2:0] a, input logic [7:0] d, input bit take);
        logic [7:0] s;
        bit ok;
        u_host_dsp_model.write(a, d, take ? 8 : 3, s, ok);
        chk_bit(ok, take, "write acceptance");
        if (take && !ok) test_done();
        if (ok && a != 3'h7) sh[a] = s;
        if (ok && a == ADDR_MODE_CONTROL && s[7]) sh = '{default: 8'h00};
        @(negedge clk);
        chk_cfg();
    endtask
    task automatic rd(input logic [2:0] a);
        q.push_back(a == 3'h7 ? 8'h00 : sh[a]);
        u_host_dsp_model.read(a);
    endtask
    task automatic read_all();
        for (int a = 0; a < 8; a++) rd(a[2:0]);
        repeat (2) @(posedge clk);
        chk_cnt(q.size(), 0, "reads left unanswered");
    endtask
    // the third gap is taken so that a freshly changed divider has settled
    task automatic gap(input int sel, input int lim, output int res);
        int n;
        n = 0;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (tick(sel) !== 1'b1 && n < lim);
        end
        if (n >= lim) begin
            fail("tick never came");
            test_done();
        end
        res = n;
    endtask
    task automatic busy_len(output int n);
        n = 0;
        while (busy === 1'b1 && n < 50) begin
            n++;
            @(negedge clk);
        end
        if (n >= 50) begin
            fail("busy never fell");
            test_done();
        end
    endtask

    always @(posedge clk) begin
        if (rd_resp.valid === 1'b1) begin
            if (q.size() == 0) fail("unexpected read answer");
            else chk8(rd_resp.data, q.pop_front());
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        fail("run limit reached");
        test_done();
    end

    initial begin
        sh = '{default: 8'h00};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        busy_len(g);
        chk_cnt(g, 4, "reset length");
        chk_cfg();
        read_all();
        gap(1, 100, g);
        chk_cnt(g, 8, "default serial clock");
        gap(2, 2100, g);
        chk_cnt(g, 2048, "default sample rate");
        // random contents for every register, program mode kept so writes stay open
        repeat (3) begin
            for (int a = 0; a < 7; a++) begin
                seed = lfsr(seed);
                do_write(a[2:0], a == 0 ? seed[7:0] & 8'h7E : seed[7:0], 1'b1);
                rd(a[2:0]);
            end
            read_all();
        end
        do_write(3'h7, 8'hA5, 1'b1);
        rd(3'h7);
        for (int c = 0; c < 8; c++) begin
            do_write(ADDR_CLOCK_RATE_CONFIG, {1'b0, c[2:0], c[1:0], 2'b00}, 1'b1);
            gap(0, 20, g);
            chk_cnt(g, c <= 4 ? c + 1 : 1, "master divider");
            gap(1, 100, g);
            chk_cnt(g, (c <= 4 ? c + 1 : 1) * (8 >> c[1:0]), "serial divider");
        end
        for (int c = 0; c < 4; c++) begin
            do_write(ADDR_CLOCK_RATE_CONFIG, {6'h00, c[1:0]}, 1'b1);
            gap(2, 2100, g);
            chk_cnt(g, 2048 >> c, "sample divider");
        end
        do_write(ADDR_MODE_CONTROL, 8'h80, 1'b1);
        busy_len(g);
        chk_cnt(g, 4, "software reset length");
        read_all();
        // data mode without mixed locks the bank until a hardware reset
        do_write(ADDR_MODE_CONTROL, 8'h21, 1'b1);
        do_write(ADDR_CLOCK_RATE_CONFIG, 8'h55, 1'b0);
        rd(ADDR_CLOCK_RATE_CONFIG);
        gap(2, 2100, g);
        for (int f = 1; f < 4; f++) begin
            u_host_dsp_model.frame();
            @(negedge clk);
            chk_bit(own_frame, f == 2, "own frame");
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        sh = '{default: 8'h00};
        @(negedge clk);
        busy_len(g);
        chk_cnt(g, 4, "second reset length");
        chk_cfg();
        do_write(ADDR_MODE_CONTROL, 8'h03, 1'b1);
        do_write(ADDR_GAIN_MUTE_CONTROL, 8'hC5, 1'b1);
        rd(ADDR_GAIN_MUTE_CONTROL);
        read_all();
        test_done();
    end
endmodule
`default_nettype wire
